// ---- design/cam_search_memory.sv ----
`timescale 1ns/10ps
`default_nettype none
module csm_cam_search_memory #(
  parameter int DEPTH = csm_pkg::DEPTH,
  parameter int WIDTH = csm_pkg::WIDTH,
  parameter logic [DEPTH*WIDTH-1:0] INIT_DATA = csm_pkg::INIT_DATA,
  parameter logic [DEPTH-1:0] INIT_VALID = csm_pkg::INIT_VALID
) (
  // Clocks and clears.
  input wire logic clk,
  input wire logic out_clk,
  input wire logic reset,
  input wire logic local_clr,
  input wire logic global_clr,
  // Configuration.
  input wire csm_pkg::csm_mode_t mode,
  input wire logic unencoded,
  input wire csm_pkg::csm_pipe_t pipe,
  input wire csm_pkg::csm_src_t src,
  // Strobes.
  input wire logic we_local,
  input wire logic we_global_net,
  input wire logic rd_strobe_local,
  input wire logic rd_strobe_global,
  // Data and locations.
  input wire logic [WIDTH-1:0] din,
  input wire logic [WIDTH-1:0] din_dc,
  input wire logic [csm_pkg::AW-1:0] wr_addr,
  input wire logic [csm_pkg::AW-1:0] rd_addr,
  // Results.
  output logic [WIDTH-1:0] q,
  output logic q_valid,
  output logic match,
  output logic half,
  output logic busy
);
  localparam int AW = csm_pkg::AW;
  localparam int LANES = csm_pkg::LANES;

  // Any clear source clears the pipeline and output registers.
  wire clr_any = reset | local_clr | global_clr; // [RULE13]

  // Strobe source selection.
  wire we_src = src.we_global ? we_global_net : we_local; // [RULE16]
  wire re_src = src.re_global ? rd_strobe_global : rd_strobe_local; // [RULE16]

  // Input pipeline stages; data and mask share one select, the others each have their own.
  logic [WIDTH-1:0] din_r;
  logic [WIDTH-1:0] dc_r;
  logic [AW-1:0] wa_r;
  logic [AW-1:0] ra_r;
  logic we_r;
  logic re_r;
  always_ff @(posedge clk or posedge clr_any) begin
    if (clr_any) begin
      din_r <= '0;
      dc_r <= '0;
      wa_r <= '0;
      ra_r <= '0;
      we_r <= 1'b0;
      re_r <= 1'b0;
    end else begin
      din_r <= din;
      dc_r <= din_dc;
      wa_r <= wr_addr;
      ra_r <= rd_addr;
      we_r <= we_src;
      re_r <= re_src;
    end
  end

  // Bypass or use each stage; the data and mask stages switch together on pipe.din.
  wire [WIDTH-1:0] din_p = pipe.din ? din_r : din; // [RULE15]
  wire [WIDTH-1:0] dc_p = pipe.din ? dc_r : din_dc; // [RULE15]
  wire [AW-1:0] wa_p = pipe.waddr ? wa_r : wr_addr; // [RULE15]
  wire [AW-1:0] ra_p = pipe.raddr ? ra_r : rd_addr; // [RULE15]
  wire we_p = pipe.we ? we_r : we_src; // [RULE15]
  wire re_p = pipe.re ? re_r : re_src; // [RULE15]

  wire is_search = (mode == csm_pkg::CSM_SEARCH);
  wire is_ram = (mode == csm_pkg::CSM_SPRAM);

  // Storage, don't-care masks and entry valid bits.
  logic [WIDTH-1:0] mem [DEPTH];
  logic [WIDTH-1:0] dcm [DEPTH];
  logic [DEPTH-1:0] vld;

  // Search write sequencer and captured write.
  csm_pkg::csm_state_t st;
  csm_pkg::csm_state_t next_st;
  logic [WIDTH-1:0] wd_q;
  logic [WIDTH-1:0] dc_q;
  logic [AW-1:0] wa_q;
  wire wr_go = we_p & is_search & (st == csm_pkg::CSM_IDLE);
  wire dc_q_any = |dc_q;
  wire commit = ((st == csm_pkg::CSM_WR1) & ~dc_q_any) | (st == csm_pkg::CSM_WR2); // [RULE9] [RULE10]
  wire ram_wr = we_p & is_ram;

  // Next state: two cycles per write, three with don't-care bits.
  always_comb begin
    next_st = st;
    case (st)
      csm_pkg::CSM_IDLE: begin
        if (wr_go) begin
          next_st = csm_pkg::CSM_WR1; // [RULE9]
        end
      end
      csm_pkg::CSM_WR1: begin
        next_st = dc_q_any ? csm_pkg::CSM_WR2 : csm_pkg::CSM_IDLE; // [RULE10]
      end
      csm_pkg::CSM_WR2: begin
        next_st = csm_pkg::CSM_IDLE;
      end
      default: begin
        next_st = csm_pkg::CSM_IDLE;
      end
    endcase
  end

  // Sequencer registers; the write is captured when it starts.
  always_ff @(posedge clk or posedge clr_any) begin
    if (clr_any) begin
      st <= csm_pkg::CSM_IDLE;
      busy <= 1'b0;
      wd_q <= '0;
      dc_q <= '0;
      wa_q <= '0;
    end else begin
      st <= next_st;
      busy <= (next_st != csm_pkg::CSM_IDLE);
      if (wr_go) begin
        wd_q <= din_p;
        dc_q <= dc_p;
        wa_q <= wa_p;
      end
    end
  end

  // Entry storage, preloaded from the configuration pattern.
  genvar g;
  for (g = 0; g < DEPTH; g++) begin : g_entry
    wire sel_cam = commit & (wa_q == AW'(g));
    wire sel_ram = ram_wr & (wa_p == AW'(g)); // [RULE12]
    always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
        mem[g] <= INIT_DATA[g*WIDTH +: WIDTH]; // [RULE11] [RULE17]
        dcm[g] <= '0;
        vld[g] <= INIT_VALID[g];
      end else if (sel_cam) begin
        mem[g] <= wd_q; // [RULE11]
        dcm[g] <= dc_q; // [RULE5]
        vld[g] <= 1'b1;
      end else if (sel_ram) begin
        mem[g] <= din_p;
        dcm[g] <= '0;
        vld[g] <= 1'b1;
      end
    end
  end

  // All entries compare with the key at once; masked bits are ignored.
  logic [DEPTH-1:0] hits;
  for (g = 0; g < DEPTH; g++) begin : g_cmp
    assign hits[g] = vld[g] & ~|((mem[g] ^ din_p) & ~dcm[g]); // [RULE2] [RULE5]
  end

  // Lowest matching index; only meaningful when entries are unique.
  function automatic logic [AW-1:0] csm_enc(input logic [DEPTH-1:0] h);
    logic [AW-1:0] r;
    r = '0;
    for (int i = DEPTH - 1; i >= 0; i--) begin
      if (h[i]) begin
        r = AW'(i);
      end
    end
    return r;
  endfunction

  // Result of the current read or search.
  csm_pkg::csm_res_t res;
  wire [AW-1:0] rd_loc = is_ram ? wa_p : ra_p; // [RULE12]
  assign res.go = re_p;
  assign res.search = is_search; // [RULE1]
  assign res.unenc = unencoded;
  assign res.flag = |hits; // [RULE3] [RULE18]
  assign res.idx = csm_enc(hits); // [RULE6] [RULE8]
  assign res.hits = hits;
  assign res.word = mem[rd_loc]; // [RULE17]

  // Output side runs on its own clock; optional output stage.
  csm_pkg::csm_res_t res_r;
  always_ff @(posedge out_clk or posedge clr_any) begin
    if (clr_any) begin
      res_r <= '0;
    end else begin
      res_r <= res;
    end
  end
  wire csm_pkg::csm_res_t osel = pipe.dout ? res_r : res; // [RULE14] [RULE15]
  wire show_lo = osel.go & osel.search & osel.unenc;

  // Output registers; unencoded map shows low half first, then high half.
  logic [DEPTH-LANES-1:0] hi_hold;
  logic pend;
  always_ff @(posedge out_clk or posedge clr_any) begin
    if (clr_any) begin
      q <= '0;
      q_valid <= 1'b0;
      match <= 1'b0;
      half <= 1'b0;
      hi_hold <= '0;
      pend <= 1'b0;
    end else if (osel.go) begin
      q_valid <= 1'b1;
      match <= osel.search & osel.flag; // [RULE3] [RULE18]
      half <= 1'b0;
      pend <= show_lo;
      hi_hold <= osel.hits[DEPTH-1:LANES];
      if (show_lo) begin
        q <= WIDTH'(osel.hits[LANES-1:0]); // [RULE7] [RULE19]
      end else if (osel.search) begin
        q <= WIDTH'(osel.idx); // [RULE1] [RULE6]
      end else begin
        q <= osel.word; // [RULE17]
      end
    end else if (pend) begin
      q <= WIDTH'(hi_hold); // [RULE7] [RULE19]
      half <= 1'b1;
      pend <= 1'b0;
      q_valid <= 1'b1;
    end else begin
      q_valid <= 1'b0;
    end
  end

  // Checks on write length, storage and output formats.
  wr_two_a: assert property (@(posedge clk) disable iff (clr_any) // [RULE9]
    (wr_go && !(|dc_p)) |=> commit ##1 !busy)
    else $error("plain write did not commit after two cycles");
  wr_three_a: assert property (@(posedge clk) disable iff (clr_any) // [RULE10]
    (wr_go && (|dc_p)) |=> !commit ##1 commit ##1 !busy)
    else $error("masked write did not commit after three cycles");
  mask_hit_a: assert property (@(posedge clk) disable iff (clr_any) // [RULE5]
    commit |=> vld[$past(wa_q)] && (mem[$past(wa_q)] == $past(wd_q)) && (dcm[$past(wa_q)] == $past(dc_q)))
    else $error("written entry or its mask not stored");
  ram_wr_a: assert property (@(posedge clk) disable iff (clr_any) // [RULE12]
    ram_wr |=> mem[$past(wa_p)] == $past(din_p))
    else $error("single-port write not stored");
  match_hi_a: assert property (@(posedge out_clk) disable iff (clr_any) // [RULE3]
    (osel.go && osel.search && (|osel.hits)) |=> match)
    else $error("match flag low on a hit");
  match_lo_a: assert property (@(posedge out_clk) disable iff (clr_any) // [RULE18]
    (osel.go && !(|osel.hits)) |=> !match)
    else $error("match flag high without a hit");
  enc_idx_a: assert property (@(posedge out_clk) disable iff (clr_any) // [RULE6]
    (osel.go && osel.search && !osel.unenc) |=> q == WIDTH'($past(osel.idx)))
    else $error("encoded index wrong");
  unenc_two_a: assert property (@(posedge out_clk) disable iff (clr_any) // [RULE19]
    (show_lo && !pipe.dout) ##1 !osel.go |-> !half ##1 (half && q == WIDTH'($past(hi_hold))))
    else $error("unencoded halves out of order");
  rom_read_a: assert property (@(posedge out_clk) disable iff (clr_any) // [RULE17]
    (osel.go && !osel.search) |=> (q == $past(osel.word)) && !match)
    else $error("lookup read returned wrong word");
  hits_par_a: assert property (@(posedge clk) disable iff (clr_any) // [RULE2]
    (re_p && is_search && vld[0] && mem[0] == din_p) |-> hits[0] && res.flag)
    else $error("entry equal to key not flagged");
endmodule // csm_cam_search_memory
`default_nettype wire

// ---- design/csm_pkg.sv ----
// Contract
// RULE1: Search mode returns the location holding a presented word, not data.
// RULE2: Every stored entry is compared with the search word at once.
// RULE3: Match flag goes high when any stored entry equals the search word.
// RULE4: One block holds 32 entries of 32 bits for searching.
// RULE5: Bits written as don't-care never stop an entry from matching.
// RULE6: Encoded output mode gives the binary index of the matching entry.
// RULE7: Unencoded mode shows one line per entry on 16 lines over two cycles.
// RULE8: Duplicate entries make the encoded result invalid; use unencoded mode then.
// RULE9: An entry write takes two clock cycles; the writer holds it meanwhile.
// RULE10: A write carrying don't-care bits takes one more cycle, three in all.
// RULE11: Contents load at configuration or by writes during operation.
// RULE12: Single-port mode shares one location port for reading and writing.
// RULE13: Every register clears asynchronously from local, global or device reset; the entry storage resets only on device reset.
// RULE14: Input-side and output-side registers may run from different clocks.
// RULE15: Each of six paths has an independently insertable pipeline register.
// RULE16: Strobes come from global or local sources; clocks from chosen sources.
// RULE17: Preloaded with a fixed pattern the block acts as a lookup table.
// RULE18: Match flag stays low when no stored entry matches the search word.
// RULE19: Unencoded first cycle covers entries 0 to 15, second 16 to 31.
package csm_pkg;
  localparam int DEPTH = 32;
  localparam int WIDTH = 32;
  localparam int AW = 5;
  localparam int LANES = 16;
  localparam logic [DEPTH*WIDTH-1:0] INIT_DATA = '0;
  localparam logic [DEPTH-1:0] INIT_VALID = '0;

  // Operating modes of the block.
  typedef enum logic [2:0] {
    CSM_SEARCH = 3'h1,
    CSM_SPRAM = 3'h2,
    CSM_ROM = 3'h4
  } csm_mode_t;

  // Write sequencer states.
  typedef enum logic [2:0] {
    CSM_IDLE = 3'h1,
    CSM_WR1 = 3'h2,
    CSM_WR2 = 3'h4
  } csm_state_t;

  // Pipeline insert selects, one per path.
  typedef struct packed {
    logic din;
    logic dout;
    logic raddr;
    logic waddr;
    logic we;
    logic re;
  } csm_pipe_t;

  // Strobe source selects, high picks the global net.
  typedef struct packed {
    logic we_global;
    logic re_global;
  } csm_src_t;

  // Result passed from the input side to the output side.
  typedef struct packed {
    logic go;
    logic search;
    logic unenc;
    logic flag;
    logic [AW-1:0] idx;
    logic [DEPTH-1:0] hits;
    logic [WIDTH-1:0] word;
  } csm_res_t;
endpackage

// ---- dv/csm_user_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// Fabric-side writer that owns the write strobe, word, mask and location.
module csm_user_model (
  // Clock and clear.
  input wire logic clk,
  input wire logic reset,
  // Commands from the bench.
  input wire logic start,
  input wire logic one_cycle,
  input wire logic [31:0] key,
  input wire logic [31:0] mask,
  input wire logic [4:0] loc,
  // Block side.
  input wire logic busy,
  output logic we,
  output logic [31:0] w_din,
  output logic [31:0] w_dc,
  output logic [4:0] w_addr
);
  // Strobe and word stay put until the block shows busy, or one cycle in RAM use.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      we <= 1'h0;
      w_din <= 32'h0;
      w_dc <= 32'h0;
      w_addr <= 5'h0;
    end else if (start && !we) begin
      we <= 1'h1;
      w_din <= key;
      w_dc <= mask;
      w_addr <= loc;
    end else if (we && (busy || one_cycle)) begin
      we <= 1'h0;
    end
  end
endmodule // csm_user_model
`default_nettype wire

// ---- dv/testbench.sv ----
`timescale 1ns/10ps
`default_nettype none
module testbench;
  typedef struct packed {logic [31:0] key; logic hit; logic [4:0] idx;} csm_row_t;
  logic clk, reset, local_clr, global_clr, unencoded, rd, start, one_cycle, we;
  logic q_valid, match, half, busy;
  logic [31:0] skey, wkey, wmask, w_din, w_dc, din, q;
  logic [4:0] wloc, w_addr;
  csm_pkg::csm_mode_t mode;
  int fails = 0;
  int tests_run = 0;
  csm_row_t rows [6] = '{'{32'h0000FA12, 1'h1, 5'hE}, '{32'h12345670, 1'h1, 5'h5},
    '{32'h1234567F, 1'h1, 5'h5}, '{32'h12345688, 1'h0, 5'h0},
    '{32'hCAFEF00D, 1'h1, 5'h1F}, '{32'h00000000, 1'h0, 5'h0}};
  // The write word wins the shared data lines while the strobe is up.
  assign din = we ? w_din : skey;
  csm_cam_search_memory dut (.clk(clk), .out_clk(clk), .reset(reset), .local_clr(local_clr),
    .global_clr(global_clr), .mode(mode), .unencoded(unencoded), .pipe('0), .src('0),
    .we_local(we), .we_global_net(1'h0), .rd_strobe_local(rd), .rd_strobe_global(1'h0),
    .din(din), .din_dc(w_dc), .wr_addr(w_addr), .rd_addr(wloc), .q(q), .q_valid(q_valid),
    .match(match), .half(half), .busy(busy));
  csm_user_model user (.clk(clk), .reset(reset), .start(start), .one_cycle(one_cycle),
    .key(wkey), .mask(wmask), .loc(wloc), .busy(busy), .we(we), .w_din(w_din), .w_dc(w_dc),
    .w_addr(w_addr));
  // Free-running clock.
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // One write through the user model; cyc is the expected length in cycles.
  task automatic wr(input logic [31:0] k, input logic [31:0] m, input logic [4:0] a,
      input logic [31:0] cyc);
    int n = 1;
    @(posedge clk) begin
      start <= 1'h1;
      wkey <= k;
      wmask <= m;
      wloc <= a;
    end
    @(posedge clk) start <= 1'h0;
    @(posedge clk);
    #1;
    while (busy === 1'h1 && n < 9) begin
      n++;
      @(posedge clk);
      #1;
    end
    chk(32'(n), cyc);
  endtask
  // One search or read strobe; returns settled at the first result cycle.
  task automatic srch(input logic [31:0] k, input logic unc);
    @(posedge clk) begin
      rd <= 1'h1;
      skey <= k;
      unencoded <= unc;
    end
    @(posedge clk) rd <= 1'h0;
    #1;
  endtask
  // Main sequence.
  initial begin
    {reset, local_clr, global_clr, unencoded, rd, start, one_cycle} = 7'h40;
    {skey, wkey, wmask, wloc} = '0;
    mode = csm_pkg::CSM_SEARCH;
    repeat (16) @(posedge clk);
    reset <= 1'h0;
    @(posedge clk);
    #1;
    chk({q, q_valid, match, half, busy}, 36'h0);
    wr(32'h0000FA12, 32'h0, 5'hE, 32'h2);
    wr(32'h12345678, 32'h0000000F, 5'h5, 32'h3);
    wr(32'hCAFEF00D, 32'h0, 5'h1F, 32'h2);
    foreach (rows[i]) begin
      srch(rows[i].key, 1'h0);
      chk({31'h0, q_valid}, 32'h1);
      chk({31'h0, match}, {31'h0, rows[i].hit});
      if (rows[i].hit) chk(q, {27'h0, rows[i].idx});
    end
    $display("table done");
    wr(32'h0000FA12, 32'h0, 5'h14, 32'h2);
    srch(32'h0000FA12, 1'h1);
    chk({q[15:0], match, half, q_valid}, {16'h4000, 3'h5});
    @(posedge clk);
    #1;
    chk({q[15:0], half, q_valid}, {16'h0010, 2'h3});
    $display("unencoded done");
    for (int c = 0; c < 2; c++) begin
      srch(32'h0000FA12, 1'h0);
      @(posedge clk) begin
        local_clr <= (c == 0);
        global_clr <= (c == 1);
      end
      @(posedge clk) {local_clr, global_clr} <= 2'h0;
      #1;
      chk({q, q_valid, match, half}, 35'h0);
      srch(32'h0000FA12, 1'h0);
      chk({q, match}, {32'hE, 1'h1});
    end
    $display("clears done");
    wr(32'h0BAD0BAD, 32'h0, 5'h0, 32'h2);
    srch(32'h0BAD0BAD, 1'h0);
    chk({q, match}, {32'h0, 1'h1});
    $display("entry zero done");
    mode <= csm_pkg::CSM_SPRAM;
    one_cycle <= 1'h1;
    wr(32'hA5A50F0F, 32'h0, 5'h7, 32'h1);
    srch(32'h0, 1'h0);
    chk({q, match, q_valid}, {32'hA5A50F0F, 2'h1});
    $display("single port done");
    mode <= csm_pkg::CSM_ROM;
    srch(32'h0, 1'h0);
    chk({q, match, q_valid}, {32'hA5A50F0F, 2'h1});
    $display("lookup done");
    close_out;
  end
  // Watchdog against a hung handshake.
  initial begin
    repeat (5000) @(posedge clk);
    fails++;
    close_out;
  end
endmodule // testbench
`default_nettype wire
